// file: pkg/seqtrg_pkg.sv
// Package with register map, field codes and timing constants of the sequence trigger engine.
package seqtrg_pkg;
  localparam int          TIMER_MIN_NS    = 100;
  localparam int          CLK_PERIOD_NS   = 50;
  localparam int          TIMER_MIN_CYC   = (TIMER_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam longint      TIMER_MAX_NS    = 64'd10_000_000_000;
  localparam int          TIMER_MAX_CYC   = int'(TIMER_MAX_NS / CLK_PERIOD_NS);
  localparam int          CHAN_W          = 20;
  localparam int          TIMER_W         = 28;
  localparam int          COUNT_W         = 16;
  // Register byte addresses.
  localparam logic [7:0]  ADDR_CTRL       = 8'h00;
  localparam logic [7:0]  ADDR_PAT1_VAL   = 8'h04;
  localparam logic [7:0]  ADDR_PAT1_MSK   = 8'h08;
  localparam logic [7:0]  ADDR_PAT2_VAL   = 8'h0C;
  localparam logic [7:0]  ADDR_PAT2_MSK   = 8'h10;
  localparam logic [7:0]  ADDR_FIRST_EDGE_TERM      = 8'h14;
  localparam logic [7:0]  ADDR_SECOND_EDGE_TERM      = 8'h18;
  localparam logic [7:0]  ADDR_FIND       = 8'h1C;
  localparam logic [7:0]  ADDR_TRIG       = 8'h20;
  localparam logic [7:0]  ADDR_RESET      = 8'h24;
  localparam logic [7:0]  ADDR_TIMER      = 8'h28;
  localparam logic [7:0]  ADDR_COUNT      = 8'h2C;
  localparam logic [7:0]  ADDR_STATUS     = 8'h30;
  // Edge register fields: bits 4:0 source (0 = none, n = channel n-1), bit 8 slope.
  localparam int          EDGE_SRC_W      = 5;
  localparam int          EDGE_SLOPE_BIT  = 8;
  // Stage field codes, three per stage, packed 3x4 bits; readback shows all three.
  localparam logic [3:0]  F_NONE          = 4'h0;
  localparam logic [3:0]  F_PAT1          = 4'h1;
  localparam logic [3:0]  F_PAT2          = 4'h2;
  localparam logic [3:0]  F_FIRST_EDGE_TERM         = 4'h3;
  localparam logic [3:0]  F_SECOND_EDGE_TERM         = 4'h4;
  localparam logic [3:0]  F_ENT           = 4'h5;
  localparam logic [3:0]  F_EXIT          = 4'h6;
  localparam logic [3:0]  F_AND           = 4'h7;
  localparam logic [3:0]  F_COUNT         = 4'h8;
  localparam logic [3:0]  F_NREF          = 4'h9;
  localparam logic [3:0]  F_TIM           = 4'hA;
  // Stage selection codes as written by software.
  localparam logic [3:0]  SEL_NONE        = 4'h0;
  localparam logic [3:0]  SEL_P1_ENT      = 4'h1;
  localparam logic [3:0]  SEL_P1_EXIT     = 4'h2;
  localparam logic [3:0]  SEL_E1          = 4'h3;
  localparam logic [3:0]  SEL_P1_AND_E1   = 4'h4;
  localparam logic [3:0]  SEL_P2_ENT      = 4'h5;
  localparam logic [3:0]  SEL_P2_EXIT     = 4'h6;
  localparam logic [3:0]  SEL_E2          = 4'h7;
  localparam logic [3:0]  SEL_P2_AND_E2   = 4'h8;
  localparam logic [3:0]  SEL_E2_COUNT    = 4'h9;
  localparam logic [3:0]  SEL_E2_CNT_NREF = 4'hA;
  localparam logic [3:0]  SEL_TIMER       = 4'hB;
  // Channel variants.
  localparam logic [1:0]  VAR_4A16D       = 2'h0;
  localparam logic [1:0]  VAR_2A16D       = 2'h1;
  localparam logic [1:0]  VAR_4A          = 2'h2;
  localparam logic [1:0]  VAR_2A          = 2'h3;
  localparam int          EXT_BIT         = 4;
  localparam int          ANA_MSO_BASE    = 16;
  localparam logic [31:0] TIMER_RESET     = 32'h0000_0002;
  localparam logic [31:0] COUNT_RESET     = 32'h0000_0001;
endpackage

// file: rtl/seqtrg_engine.sv
// Sequence trigger engine: find, trigger and reset stages over pattern, edge, counter and timer resources.
//
// The implementer's own choices: the placing of the registers and the APB register port.
`timescale 1ns/1ps
module seqtrg_engine #(
  parameter logic [1:0] VARIANT   = seqtrg_pkg::VAR_4A16D,  // Channel variant.
  parameter int         TIMER_MAX = seqtrg_pkg::TIMER_MAX_CYC // Longest timer in cycles.
) (
  input  wire logic        sys_clk,     // 20 MHz clock.
  input  wire logic        reset,       // Synchronous reset, active high.
  input  wire logic [3:0]  analog_lvl,  // Analog comparator levels, channels 1 to 4.
  input  wire logic [15:0] digital_lvl, // Digital probe levels.
  input  wire logic        ext_lvl,     // External trigger input level.
  input  wire logic        psel,        // APB select.
  input  wire logic        penable,     // APB enable.
  input  wire logic        pwrite,      // APB direction.
  input  wire logic [7:0]  paddr,       // APB byte address.
  input  wire logic [31:0] pwdata,      // APB write data.
  input  wire logic [3:0]  pstrb,       // APB byte strobes.
  output logic [31:0]      prdata,      // APB read data.
  output logic             pready,      // APB ready.
  output logic             pslverr,     // APB error on unmapped address.
  output logic             trig_out     // One-cycle trigger pulse.
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_FIND = 3'b010,
    ST_TRIG = 3'b100
  } seqtrg_state_e;

  localparam int CW = seqtrg_pkg::CHAN_W;

  seqtrg_state_e state_ff;
  logic [CW-1:0] chan_meta_ff, chan_sync_ff, chan_prev_ff;
  logic [CW-1:0] pat1_val_ff, pat1_msk_ff, pat2_val_ff, pat2_msk_ff;
  logic [31:0]   first_edge_term_ff, second_edge_term_ff, timer_cfg_ff, count_cfg_ff;
  logic [3:0]    find_sel_ff, trig_sel_ff, rst_sel_ff;
  logic          enable_ff;
  logic          p1_prev_ff, p2_prev_ff;
  logic [seqtrg_pkg::TIMER_W-1:0] timer_ff;
  logic [seqtrg_pkg::COUNT_W-1:0] edge_cnt_ff;
  logic [CW-1:0] chan_raw;
  logic          p1_now, p2_now, p1_ent, p1_exit, p2_ent, p2_exit;
  logic          e1_hit, e2_hit, timer_exp;
  logic          find_hit, trig_cond, trig_hit, rst_hit;
  logic          apb_wr, apb_rd, addr_ok;
  logic [seqtrg_pkg::TIMER_W-1:0] timer_lim;
  logic [31:0]   timer_wr;

  // Channel mapping into pattern bit positions per variant.
  always_comb begin
    chan_raw = '0;
    unique case (VARIANT)
      seqtrg_pkg::VAR_4A16D: begin
        chan_raw[15:0]                               = digital_lvl;
        chan_raw[seqtrg_pkg::ANA_MSO_BASE +: 4]      = analog_lvl;
      end
      seqtrg_pkg::VAR_2A16D: begin
        chan_raw[15:0]                               = digital_lvl;
        chan_raw[seqtrg_pkg::ANA_MSO_BASE +: 2]      = analog_lvl[1:0];
      end
      seqtrg_pkg::VAR_4A: begin
        chan_raw[3:0]                   = analog_lvl;
        chan_raw[seqtrg_pkg::EXT_BIT]   = ext_lvl;
      end
      seqtrg_pkg::VAR_2A: begin
        chan_raw[1:0]                   = analog_lvl[1:0];
        chan_raw[seqtrg_pkg::EXT_BIT]   = ext_lvl;
      end
    endcase
  end

  // Levels come from outside this clock domain, so two flip-flops first.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      chan_meta_ff <= '0;
      chan_sync_ff <= '0;
      chan_prev_ff <= '0;
    end else begin
      chan_meta_ff <= chan_raw;
      chan_sync_ff <= chan_meta_ff;
      chan_prev_ff <= chan_sync_ff;
    end
  end

  // A masked-out channel never fails the match.
  assign p1_now = &(~(chan_sync_ff ^ pat1_val_ff) | ~pat1_msk_ff);
  assign p2_now = &(~(chan_sync_ff ^ pat2_val_ff) | ~pat2_msk_ff);

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      p1_prev_ff <= 1'b0;
      p2_prev_ff <= 1'b0;
    end else begin
      p1_prev_ff <= p1_now;
      p2_prev_ff <= p2_now;
    end
  end

  assign p1_ent  = p1_now & ~p1_prev_ff;
  assign p1_exit = ~p1_now & p1_prev_ff;
  assign p2_ent  = p2_now & ~p2_prev_ff;
  assign p2_exit = ~p2_now & p2_prev_ff;

  function automatic logic edge_fire(input logic [31:0] cfg, input logic [CW-1:0] cur,
                                     input logic [CW-1:0] prv);
    logic [seqtrg_pkg::EDGE_SRC_W-1:0] src;
    logic                              c, p;
    src = cfg[seqtrg_pkg::EDGE_SRC_W-1:0];
    c   = 1'b0;
    p   = 1'b0;
    if (src != '0 && int'(src) <= CW) begin
      c = cur[src - 1'b1];
      p = prv[src - 1'b1];
    end
    // Source code zero selects no channel and the resource never fires.
    if (src == '0)
      edge_fire = 1'b0;
    else if (cfg[seqtrg_pkg::EDGE_SLOPE_BIT])
      edge_fire = p & ~c;
    else
      edge_fire = c & ~p;
  endfunction

  assign e1_hit = edge_fire(first_edge_term_ff, chan_sync_ff, chan_prev_ff);
  assign e2_hit = edge_fire(second_edge_term_ff, chan_sync_ff, chan_prev_ff);

  always_comb begin
    unique case (find_sel_ff)
      seqtrg_pkg::SEL_P1_ENT:    find_hit = p1_ent;
      seqtrg_pkg::SEL_P1_EXIT:   find_hit = p1_exit;
      seqtrg_pkg::SEL_E1:        find_hit = e1_hit;
      seqtrg_pkg::SEL_P1_AND_E1: find_hit = p1_now & e1_hit;
      default:                   find_hit = 1'b0;
    endcase
  end

  always_comb begin
    unique case (trig_sel_ff)
      seqtrg_pkg::SEL_P2_ENT:      trig_cond = p2_ent;
      seqtrg_pkg::SEL_P2_EXIT:     trig_cond = p2_exit;
      seqtrg_pkg::SEL_E2:          trig_cond = e2_hit;
      seqtrg_pkg::SEL_P2_AND_E2:   trig_cond = p2_now & e2_hit;
      seqtrg_pkg::SEL_E2_COUNT,
      seqtrg_pkg::SEL_E2_CNT_NREF: trig_cond = e2_hit;
      default:                     trig_cond = 1'b0;
    endcase
  end

  logic counted;
  assign counted  = (trig_sel_ff == seqtrg_pkg::SEL_E2_COUNT) || (trig_sel_ff == seqtrg_pkg::SEL_E2_CNT_NREF);
  // In counted modes the last needed edge is the trigger.
  assign trig_hit = trig_cond &
                    (!counted || (32'(edge_cnt_ff) + 32'd1 >= count_cfg_ff));

  // The written time is clamped on entry, so a readback shows the time in force.
  assign timer_wr  = (pwdata < 32'(seqtrg_pkg::TIMER_MIN_CYC)) ? 32'(seqtrg_pkg::TIMER_MIN_CYC) :
                     (pwdata > 32'(TIMER_MAX)) ? 32'(TIMER_MAX) : pwdata;
  assign timer_lim = timer_cfg_ff[seqtrg_pkg::TIMER_W-1:0];
  assign timer_exp = (state_ff == ST_TRIG) && (timer_ff >= timer_lim - 1'b1);

  always_comb begin
    unique case (rst_sel_ff)
      seqtrg_pkg::SEL_P1_ENT:    rst_hit = p1_ent;
      seqtrg_pkg::SEL_P1_EXIT:   rst_hit = p1_exit;
      seqtrg_pkg::SEL_E1:        rst_hit = e1_hit;
      seqtrg_pkg::SEL_P1_AND_E1: rst_hit = p1_now & e1_hit;
      seqtrg_pkg::SEL_P2_ENT:    rst_hit = p2_ent;
      seqtrg_pkg::SEL_P2_EXIT:   rst_hit = p2_exit;
      seqtrg_pkg::SEL_E2:        rst_hit = e2_hit;
      seqtrg_pkg::SEL_TIMER:     rst_hit = timer_exp;
      default:                   rst_hit = 1'b0;
    endcase
  end

  // Sequencer state. Reset wins over a trigger in the same cycle, since
  // software is expected to keep the two conditions disjoint anyway.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state_ff <= ST_IDLE;
      trig_out <= 1'b0;
    end else begin
      trig_out <= 1'b0;
      unique case (state_ff)
        ST_IDLE: if (enable_ff) state_ff <= ST_FIND;
        ST_FIND: begin
          if (!enable_ff) state_ff <= ST_IDLE;
          else if (find_hit) state_ff <= ST_TRIG;
        end
        ST_TRIG: begin
          if (!enable_ff) state_ff <= ST_IDLE;
          else if (rst_hit) state_ff <= ST_FIND;
          else if (trig_hit) begin
            trig_out <= 1'b1;
            state_ff <= ST_FIND;
          end else if (counted && trig_sel_ff == seqtrg_pkg::SEL_E2_COUNT && trig_cond)
            state_ff <= ST_FIND;                  // Plain counted mode must refind between edges.
        end
      endcase
    end
  end

  // Edge counter: kept across refinds only in plain counted mode, and through
  // the no-refind mode, which never leaves the trigger state between edges.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      edge_cnt_ff <= '0;
    end else if (state_ff == ST_IDLE || (state_ff == ST_TRIG && (rst_hit || trig_hit))) begin
      edge_cnt_ff <= '0;
    end else if (state_ff == ST_TRIG && counted && trig_cond) begin
      edge_cnt_ff <= edge_cnt_ff + 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      timer_ff <= '0;
    end else if (state_ff != ST_TRIG || rst_hit || trig_hit) begin
      timer_ff <= '0;
    end else begin
      timer_ff <= timer_ff + 1'b1;
    end
  end

  // APB slave, zero wait states.
  assign pready  = 1'b1;
  assign apb_wr  = psel & penable & pwrite;
  assign apb_rd  = psel & ~pwrite;
  assign addr_ok = (paddr <= seqtrg_pkg::ADDR_STATUS) && (paddr[1:0] == 2'b00);
  assign pslverr = psel & penable & ~addr_ok;

  function automatic logic [31:0] stage_fields(input logic [3:0] sel);
    logic [3:0] a, b, c;
    a = seqtrg_pkg::F_NONE;
    b = seqtrg_pkg::F_NONE;
    c = seqtrg_pkg::F_NONE;
    unique case (sel)
      seqtrg_pkg::SEL_P1_ENT:      begin a = seqtrg_pkg::F_PAT1;  b = seqtrg_pkg::F_ENT;   end
      seqtrg_pkg::SEL_P1_EXIT:     begin a = seqtrg_pkg::F_PAT1;  b = seqtrg_pkg::F_EXIT;  end
      seqtrg_pkg::SEL_E1:          a = seqtrg_pkg::F_FIRST_EDGE_TERM;
      seqtrg_pkg::SEL_P1_AND_E1:   begin a = seqtrg_pkg::F_PAT1; b = seqtrg_pkg::F_AND; c = seqtrg_pkg::F_FIRST_EDGE_TERM; end
      seqtrg_pkg::SEL_P2_ENT:      begin a = seqtrg_pkg::F_PAT2;  b = seqtrg_pkg::F_ENT;   end
      seqtrg_pkg::SEL_P2_EXIT:     begin a = seqtrg_pkg::F_PAT2;  b = seqtrg_pkg::F_EXIT;  end
      seqtrg_pkg::SEL_E2:          a = seqtrg_pkg::F_SECOND_EDGE_TERM;
      seqtrg_pkg::SEL_P2_AND_E2:   begin a = seqtrg_pkg::F_PAT2; b = seqtrg_pkg::F_AND; c = seqtrg_pkg::F_SECOND_EDGE_TERM; end
      seqtrg_pkg::SEL_E2_COUNT:    begin a = seqtrg_pkg::F_SECOND_EDGE_TERM; b = seqtrg_pkg::F_COUNT; end
      seqtrg_pkg::SEL_E2_CNT_NREF: begin a = seqtrg_pkg::F_SECOND_EDGE_TERM; b = seqtrg_pkg::F_COUNT; c = seqtrg_pkg::F_NREF; end
      seqtrg_pkg::SEL_TIMER:       a = seqtrg_pkg::F_TIM;
      default: ;
    endcase
    stage_fields = {20'h0_0000, a, b, c};
  endfunction

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      enable_ff    <= 1'b0;
      pat1_val_ff  <= '0;
      pat1_msk_ff  <= '0;
      pat2_val_ff  <= '0;
      pat2_msk_ff  <= '0;
      first_edge_term_ff     <= '0;
      second_edge_term_ff     <= '0;
      find_sel_ff  <= seqtrg_pkg::SEL_E1;
      trig_sel_ff  <= seqtrg_pkg::SEL_E2;
      rst_sel_ff   <= seqtrg_pkg::SEL_NONE;
      timer_cfg_ff <= seqtrg_pkg::TIMER_RESET;
      count_cfg_ff <= seqtrg_pkg::COUNT_RESET;
    end else if (apb_wr && pstrb == 4'hF) begin
      unique case (paddr)
        seqtrg_pkg::ADDR_CTRL:     enable_ff   <= pwdata[0];
        seqtrg_pkg::ADDR_PAT1_VAL: pat1_val_ff <= pwdata[CW-1:0];
        seqtrg_pkg::ADDR_PAT1_MSK: pat1_msk_ff <= pwdata[CW-1:0];
        seqtrg_pkg::ADDR_PAT2_VAL: pat2_val_ff <= pwdata[CW-1:0];
        seqtrg_pkg::ADDR_PAT2_MSK: pat2_msk_ff <= pwdata[CW-1:0];
        seqtrg_pkg::ADDR_FIRST_EDGE_TERM:    first_edge_term_ff    <= pwdata;
        seqtrg_pkg::ADDR_SECOND_EDGE_TERM:    second_edge_term_ff    <= pwdata;
        seqtrg_pkg::ADDR_FIND:     if (pwdata[3:0] >= seqtrg_pkg::SEL_P1_ENT && pwdata[3:0] <= seqtrg_pkg::SEL_P1_AND_E1)
                                     find_sel_ff <= pwdata[3:0];
        seqtrg_pkg::ADDR_TRIG:     if (pwdata[3:0] >= seqtrg_pkg::SEL_P2_ENT && pwdata[3:0] <= seqtrg_pkg::SEL_E2_CNT_NREF)
                                     trig_sel_ff <= pwdata[3:0];
        seqtrg_pkg::ADDR_RESET:    if (pwdata[3:0] <= seqtrg_pkg::SEL_E2 || pwdata[3:0] == seqtrg_pkg::SEL_TIMER)
                                     rst_sel_ff  <= pwdata[3:0];
        seqtrg_pkg::ADDR_TIMER:    timer_cfg_ff <= timer_wr;
        seqtrg_pkg::ADDR_COUNT:    count_cfg_ff <= pwdata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      prdata <= '0;
    end else if (apb_rd && !penable) begin
      unique case (paddr)
        seqtrg_pkg::ADDR_CTRL:     prdata <= {31'h0, enable_ff};
        seqtrg_pkg::ADDR_PAT1_VAL: prdata <= 32'(pat1_val_ff);
        seqtrg_pkg::ADDR_PAT1_MSK: prdata <= 32'(pat1_msk_ff);
        seqtrg_pkg::ADDR_PAT2_VAL: prdata <= 32'(pat2_val_ff);
        seqtrg_pkg::ADDR_PAT2_MSK: prdata <= 32'(pat2_msk_ff);
        seqtrg_pkg::ADDR_FIRST_EDGE_TERM:    prdata <= first_edge_term_ff;
        seqtrg_pkg::ADDR_SECOND_EDGE_TERM:    prdata <= second_edge_term_ff;
        seqtrg_pkg::ADDR_FIND:     prdata <= stage_fields(find_sel_ff);
        seqtrg_pkg::ADDR_TRIG:     prdata <= stage_fields(trig_sel_ff);
        seqtrg_pkg::ADDR_RESET:    prdata <= stage_fields(rst_sel_ff);
        seqtrg_pkg::ADDR_TIMER:    prdata <= timer_cfg_ff;
        seqtrg_pkg::ADDR_COUNT:    prdata <= count_cfg_ff;
        seqtrg_pkg::ADDR_STATUS:   prdata <= {13'h0, state_ff, edge_cnt_ff};
        default:                   prdata <= '0;
      endcase
    end
  end

  a_trig_needs_find: assert property (@(posedge sys_clk) disable iff (reset)
    trig_out |-> $past(state_ff) == ST_TRIG) else $error("trigger without find");
  a_find_advances: assert property (@(posedge sys_clk) disable iff (reset)
    (state_ff == ST_FIND && enable_ff && find_hit) |=> state_ff == ST_TRIG) else $error("find not taken");
  a_reset_restarts: assert property (@(posedge sys_clk) disable iff (reset)
    (state_ff == ST_TRIG && enable_ff && rst_hit) |=> (state_ff == ST_FIND && !trig_out)) else $error("no restart");
  a_timer_cleared: assert property (@(posedge sys_clk) disable iff (reset)
    (state_ff != ST_TRIG) |=> timer_ff == '0) else $error("timer not cleared");
  a_timer_counts: assert property (@(posedge sys_clk) disable iff (reset)
    (state_ff == ST_TRIG && $past(state_ff) == ST_TRIG && !$past(rst_hit) && !$past(trig_hit))
    |-> timer_ff == $past(timer_ff) + 1'b1) else $error("timer stalled");
  a_count_gate: assert property (@(posedge sys_clk) disable iff (reset)
    (trig_out && $past(counted)) |-> 32'($past(edge_cnt_ff)) + 32'd1 >= $past(count_cfg_ff)) else $error("early count");
  a_edge_disabled: assert property (@(posedge sys_clk) disable iff (reset)
    (first_edge_term_ff[seqtrg_pkg::EDGE_SRC_W-1:0] == '0) |-> !e1_hit) else $error("disabled edge fired");
  a_trig_pulse: assert property (@(posedge sys_clk) disable iff (reset)
    trig_out |=> !trig_out) else $error("trigger not one cycle");
endmodule // seqtrg_engine

// file: tb/seqtrg_chan_model.sv
// Channel level source that stands in for the comparators and digital probes feeding the engine.
`timescale 1ns/1ps
module seqtrg_chan_model (
  input  wire logic        sys_clk,     // Sample clock.
  input  wire logic [19:0] lvl_word,    // Wanted level for each pattern bit.
  output logic      [3:0]  analog_lvl,  // Comparator levels, channels 1 to 4.
  output logic      [15:0] digital_lvl, // Probe levels.
  output logic             ext_lvl      // External input level.
);
  logic ext_tgl_ff = 1'b0;
  assign ext_lvl = ext_tgl_ff;
  // The external input has no pattern bit on this variant, so it toggles to expose any stray use.
  always @(posedge sys_clk) begin
    digital_lvl <= lvl_word[15:0];
    analog_lvl  <= lvl_word[19:16];
    ext_tgl_ff  <= ~ext_tgl_ff;
  end
endmodule // seqtrg_chan_model

// file: tb/tb_seqtrg_engine.sv
// Self-checking bench for the sequence trigger engine over APB and channel levels.
`timescale 1ns/1ps
module tb_seqtrg_engine;
  localparam logic [11:0] FLD [12] = '{12'h000, 12'h150, 12'h160, 12'h300, 12'h173, 12'h250,
                                       12'h260, 12'h400, 12'h274, 12'h480, 12'h489, 12'hA00};
  localparam logic [11:0] OKM [3]  = '{12'h01E, 12'h7E0, 12'h8FF};
  localparam logic [11:0] RV  [3]  = '{12'h300, 12'h400, 12'h000};
  localparam logic [7:0]  SA  [3]  = '{seqtrg_pkg::ADDR_FIND, seqtrg_pkg::ADDR_TRIG, seqtrg_pkg::ADDR_RESET};
  logic        sys_clk  = 1'b0;
  logic        reset    = 1'b1;
  logic        psel     = 1'b0;
  logic        penable  = 1'b0;
  logic        pwrite   = 1'b0;
  logic [7:0]  paddr    = 8'h00;
  logic [31:0] pwdata   = 32'h0000_0000;
  logic [19:0] lvl_word = 20'h0_0000;
  logic [3:0]  pstrb    = 4'hF;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, trig_out, err, ext_lvl;
  logic [3:0]  analog_lvl;
  logic [15:0] digital_lvl;
  logic [19:0] pval, w, off;
  logic [11:0] prev;
  int          n_errors = 0;
  int          compares = 0;
  int          pulses;

  always #25 sys_clk = ~sys_clk;

  seqtrg_chan_model seqtrg_chan_model_i (.sys_clk(sys_clk), .lvl_word(lvl_word), .analog_lvl(analog_lvl),
    .digital_lvl(digital_lvl), .ext_lvl(ext_lvl));
  seqtrg_engine #(.VARIANT(seqtrg_pkg::VAR_4A16D), .TIMER_MAX(64)) seqtrg_engine_i (.sys_clk(sys_clk),
    .reset(reset), .analog_lvl(analog_lvl), .digital_lvl(digital_lvl), .ext_lvl(ext_lvl), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .trig_out(trig_out));

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic give_verdict();
    if (n_errors == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge sys_clk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    for (i = 0; i < 16; i++) begin
      @(posedge sys_clk);
      if (pready === 1'b1) break;
    end
    if (i == 16) begin
      n_errors++;
      give_verdict();
    end
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Holds a level word for n cycles and counts trigger pulses meanwhile.
  task automatic lv(input logic [19:0] v, input int n);
    @(posedge sys_clk);
    lvl_word <= v;
    repeat (n) begin
      @(negedge sys_clk);
      if (trig_out === 1'b1) pulses++;
    end
  endtask

  initial begin
    repeat (100000) @(posedge sys_clk);
    n_errors++;
    give_verdict();
  end

  initial begin
    void'($urandom(32'h8ff2));
    repeat (16) @(posedge sys_clk);
    reset <= 1'b0;
    apb(1'b0, seqtrg_pkg::ADDR_COUNT, 32'h0000_0000);
    chk("count reset", 32'h0000_0001, rd);
    pstrb <= 4'h3;
    apb(1'b1, seqtrg_pkg::ADDR_COUNT, 32'h0000_0007);
    pstrb <= 4'hF;
    apb(1'b0, seqtrg_pkg::ADDR_COUNT, 32'h0000_0000);
    chk("partial write", 32'h0000_0001, rd);
    apb(1'b0, 8'h34, 32'h0000_0000);
    chk("unmapped", 32'h0000_0001, {31'h0000_0000, err});
    chk("unmapped data", 32'h0000_0000, rd);
    for (int r = 0; r < 3; r++) begin
      prev = RV[r];
      for (int c = 0; c < 12; c++) begin
        apb(1'b1, SA[r], {28'h000_0000, 4'(c)});
        if (OKM[r][c]) prev = FLD[c];
        apb(1'b0, SA[r], 32'h0000_0000);
        chk("stage fields", {20'h0_0000, prev}, rd);
      end
    end
    apb(1'b1, seqtrg_pkg::ADDR_TIMER, 32'h0000_0000);
    apb(1'b0, seqtrg_pkg::ADDR_TIMER, 32'h0000_0000);
    chk("timer min", 32'h0000_0002, rd);
    apb(1'b1, seqtrg_pkg::ADDR_TIMER, 32'h0000_FFFF);
    apb(1'b0, seqtrg_pkg::ADDR_TIMER, 32'h0000_0000);
    chk("timer max", 32'h0000_0040, rd);
    // Pattern 1 watches digital 0..7; bits 8 to 11 and 15 to 19 carry random noise that must be ignored.
    pval = 20'($urandom()) & 20'h0_00FF;
    off  = ~pval & 20'h0_00FF;
    w    = pval | (20'($urandom()) & 20'hF_8F00);
    apb(1'b1, seqtrg_pkg::ADDR_PAT1_MSK, 32'h0000_00FF);
    apb(1'b1, seqtrg_pkg::ADDR_PAT1_VAL, {12'h000, pval});
    apb(1'b1, seqtrg_pkg::ADDR_SECOND_EDGE_TERM, 32'h0000_000D);
    apb(1'b1, seqtrg_pkg::ADDR_FIND, {28'h000_0000, seqtrg_pkg::SEL_P1_ENT});
    apb(1'b1, seqtrg_pkg::ADDR_TRIG, {28'h000_0000, seqtrg_pkg::SEL_E2});
    apb(1'b1, seqtrg_pkg::ADDR_RESET, {28'h000_0000, seqtrg_pkg::SEL_NONE});
    apb(1'b1, seqtrg_pkg::ADDR_CTRL, 32'h0000_0001);
    pulses = 0;
    lv(off, 8);
    lv(off | 20'h0_1000, 8);
    lv(off, 8);
    chk("edge before find", 32'h0000_0000, pulses);
    lv(w, 8);
    lv(w | 20'h0_1000, 8);
    chk("single trigger", 32'h0000_0001, pulses);
    apb(1'b1, seqtrg_pkg::ADDR_COUNT, 32'h0000_0003);
    apb(1'b1, seqtrg_pkg::ADDR_TRIG, {28'h000_0000, seqtrg_pkg::SEL_E2_CNT_NREF});
    lv(off, 8);
    lv(w, 8);
    pulses = 0;
    repeat (2) begin
      lv(w | 20'h0_1000, 6);
      lv(w, 6);
    end
    chk("early count", 32'h0000_0000, pulses);
    lv(w | 20'h0_1000, 8);
    chk("count trigger", 32'h0000_0001, pulses);
    apb(1'b1, seqtrg_pkg::ADDR_TIMER, 32'h0000_000A);
    apb(1'b1, seqtrg_pkg::ADDR_TRIG, {28'h000_0000, seqtrg_pkg::SEL_E2});
    apb(1'b1, seqtrg_pkg::ADDR_RESET, {28'h000_0000, seqtrg_pkg::SEL_TIMER});
    lv(off, 8);
    lv(w, 4);
    apb(1'b0, seqtrg_pkg::ADDR_STATUS, 32'h0000_0000);
    chk("trigger stage", 32'h0000_0004, {29'h0000_0000, rd[18:16]});
    lv(w, 20);
    apb(1'b0, seqtrg_pkg::ADDR_STATUS, 32'h0000_0000);
    chk("timer restart", 32'h0000_0002, {29'h0000_0000, rd[18:16]});
    pulses = 0;
    lv(w | 20'h0_1000, 8);
    chk("no trigger after restart", 32'h0000_0000, pulses);
    // Plain counted mode: an edge seen while back in the find stage must not count.
    apb(1'b1, seqtrg_pkg::ADDR_RESET, {28'h000_0000, seqtrg_pkg::SEL_NONE});
    apb(1'b1, seqtrg_pkg::ADDR_TRIG, {28'h000_0000, seqtrg_pkg::SEL_E2_COUNT});
    pulses = 0;
    for (int k = 0; k < 3; k++) begin
      lv(off, 6);
      lv(w, 6);
      lv(w | 20'h0_1000, 6);
      lv(w, 6);
      if (k == 0) begin
        lv(w | 20'h0_1000, 6);
        apb(1'b0, seqtrg_pkg::ADDR_STATUS, 32'h0000_0000);
        chk("count held", 32'h0000_0001, {16'h0000, rd[15:0]});
      end
    end
    chk("refind trigger", 32'h0000_0001, pulses);
    // Falling edge 1 finds, pattern 2 entry triggers, pattern 1 entry restarts.
    apb(1'b1, seqtrg_pkg::ADDR_FIRST_EDGE_TERM, 32'h0000_010E);
    apb(1'b1, seqtrg_pkg::ADDR_PAT2_MSK, 32'h0000_4000);
    apb(1'b1, seqtrg_pkg::ADDR_PAT2_VAL, 32'h0000_4000);
    apb(1'b1, seqtrg_pkg::ADDR_TRIG, {28'h000_0000, seqtrg_pkg::SEL_P2_ENT});
    apb(1'b1, seqtrg_pkg::ADDR_RESET, {28'h000_0000, seqtrg_pkg::SEL_P1_ENT});
    apb(1'b1, seqtrg_pkg::ADDR_FIND, {28'h000_0000, seqtrg_pkg::SEL_E1});
    pulses = 0;
    lv(off | 20'h0_2000, 6);
    lv(off, 6);
    lv(w, 6);
    lv(w | 20'h0_4000, 6);
    chk("reset abandons", 32'h0000_0000, pulses);
    lv(off | 20'h0_6000, 6);
    lv(off | 20'h0_4000, 6);
    lv(off, 6);
    lv(off | 20'h0_4000, 8);
    chk("second_pattern_term trigger", 32'h0000_0001, pulses);
    give_verdict();
  end
endmodule // tb_seqtrg_engine
